// ==== occ_channel.sv ====
// Purpose: one output compare channel with APB registers, faults and PWM
// Assumes: all inputs synchronous to ref_clk; timer ticks and events are pulses
// Notes:   instantiate once per channel; pair odd/even channels for 32 bits
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps

module occ_channel
   import occ_pkg::*;
#(
   parameter int CHAN_NUM = 1,                         // channel number 1..16
   parameter int DW       = 16                         // timer width
) (
   input  wire logic          ref_clk,                 // system clock
   input  wire logic          rst,                     // synchronous reset
   input  wire logic [11:0]   paddr,                   // apb address
   input  wire logic          psel,                    // apb select
   input  wire logic          penable,                 // apb enable
   input  wire logic          pwrite,                  // apb direction
   input  wire logic [31:0]   pwdata,                  // apb write data
   input  wire logic [3:0]    pstrb,                   // apb byte strobes
   output logic      [31:0]   prdata,                  // apb read data
   output logic               pready,                  // apb ready
   output logic               pslverr,                 // apb error
   input  wire logic [4:0]    timer_tick,              // timer one..five ticks
   input  wire logic [31:0]   src_event,               // trigger/sync sources
   input  wire logic          fault_input_a,           // shared fault a
   input  wire logic          fault_input_b,           // shared fault b
   input  wire logic          fault_input_c,           // shared fault c
   input  wire logic          cascade_lo_wrap_in,      // low half wrapped
   input  wire logic          cascade_lo_match_in,     // low half matched
   output logic               cascade_wrap_out,        // this half wrapped
   output logic               cascade_match_out,       // this half matched
   output logic               pin_out,                 // compare pin level
   output logic               pin_oe,                  // compare pin drive
   output logic               dma_req                  // reload request pulse
);

   // merge strobed low lanes of write data into a register under a mask
   function automatic logic [15:0] occ_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] st, input logic [15:0] msk);
      logic [15:0] n;
      n = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
      return (n & msk) | (old & ~msk);
   endfunction : occ_merge

   // timebase pick: timers, instruction clock, or nothing for reserved codes
   function automatic logic occ_tb_pick(input logic [2:0] sel, input logic [4:0] tmr,
                                        input logic instruction_cycle_clock);
      if (sel == OCC_TB_TCY)
         return instruction_cycle_clock;
      else if (sel < OCC_TB_TIMERS)
         return tmr[sel];
      else
         return 1'b0;
   endfunction : occ_tb_pick

   localparam bit HI_HALF_CHAN = (CHAN_NUM % 2) == 0;  // even number is upper half
   localparam bit DMA_CAPABLE  = CHAN_NUM <= 4;

   logic [15:0]   con1_reg;
   logic [15:0]   con2_reg;
   logic [2:0]    fstat_reg;
   logic          flag_reg;
   logic [DW-1:0] per_buf_reg;
   logic [DW-1:0] duty_buf_reg;
   logic [DW-1:0] per_act_reg;
   logic [DW-1:0] duty_act_reg;
   logic [DW-1:0] cnt_reg;
   logic [3:0]    div_reg;
   occ_state_t    state_reg;
   logic          level_reg;
   logic          done_reg;
   logic          pin_out_reg;
   logic          pin_oe_reg;
   logic          dma_reg;
   logic [31:0]   prdata_reg;

   occ_con1_t     c1;
   occ_con2_t     c2;
   logic          wr;
   logic          wr_con1;
   logic          wr_con2;
   logic          wr_per;
   logic          wr_duty;
   logic          mapped;
   logic          tcy_en;
   logic          hi_half;
   logic          tick;
   logic          run;
   logic          trig_mode;
   logic          evt_sel;
   logic          wrap;
   logic          hit;
   logic          at_per;
   logic [2:0]    fin;
   logic [2:0]    fhit;
   logic          fault_act;
   logic [DW-1:0] ctr_lo;
   logic          in_win;

   // register views; status and flag live in their own flops
   assign c1 = occ_con1_t'({con1_reg[15:7], fstat_reg, con1_reg[3:0]});
   assign c2 = occ_con2_t'({con2_reg[15:7], flag_reg, con2_reg[5:0]});

   // apb decode: zero wait states, error on unmapped offsets
   assign mapped  = (paddr == OCC_CON1_OFS) || (paddr == OCC_CON2_OFS) || (paddr == OCC_PER_OFS) ||
                    (paddr == OCC_DUTY_OFS) || (paddr == OCC_CNT_OFS);
   assign wr      = psel && penable && pwrite;
   assign wr_con1 = wr && (paddr == OCC_CON1_OFS);
   assign wr_con2 = wr && (paddr == OCC_CON2_OFS);
   assign wr_per  = wr && (paddr == OCC_PER_OFS);
   assign wr_duty = wr && (paddr == OCC_DUTY_OFS);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_reg;

   // read data captured in the setup phase
   always_ff @(posedge ref_clk) begin
      if (rst)
         prdata_reg <= 32'h0000_0000;
      else if (psel && !penable) begin
         case (paddr)
            OCC_CON1_OFS: prdata_reg <= {16'h0000, c1};
            OCC_CON2_OFS: prdata_reg <= {16'h0000, c2};
            OCC_PER_OFS:  prdata_reg <= 32'(per_buf_reg);
            OCC_DUTY_OFS: prdata_reg <= 32'(duty_buf_reg);
            OCC_CNT_OFS:  prdata_reg <= 32'(cnt_reg);
            default:      prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // control registers and buffered compare values
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         con1_reg     <= OCC_CON1_RST;
         con2_reg     <= OCC_CON2_RST;
         per_buf_reg  <= DW'(OCC_PER_RST);
         duty_buf_reg <= DW'(OCC_DUTY_RST);
      end else begin
         if (wr_con1)
            con1_reg <= occ_merge(con1_reg, pwdata, pstrb, OCC_CON1_WMASK);
         if (wr_con2)
            con2_reg <= occ_merge(con2_reg, pwdata, pstrb, OCC_CON2_WMASK);
         if (wr_per)
            per_buf_reg <= DW'(occ_merge(16'(per_buf_reg), pwdata, pstrb, OCC_ALL_WMASK));
         if (wr_duty)
            duty_buf_reg <= DW'(occ_merge(16'(duty_buf_reg), pwdata, pstrb, OCC_ALL_WMASK));
      end
   end

   // instruction clock enable from the divider
   always_ff @(posedge ref_clk) begin
      if (rst)
         div_reg <= 4'h0;
      else if (div_reg == OCC_TCY_LAST)
         div_reg <= 4'h0;
      else
         div_reg <= div_reg + 4'h1;
   end
   assign tcy_en = (div_reg == OCC_TCY_LAST);

   // timebase, cascade gating, source select and compare events
   assign hi_half   = c2.cascade_pair_enable && HI_HALF_CHAN;
   assign tick      = occ_tb_pick(c1.timebase_select, timer_tick, tcy_en) &&
                      (!hi_half || cascade_lo_wrap_in);
   assign trig_mode = c2.trigger_not_sync_select;
   assign evt_sel   = (c2.sync_source_select != OCC_SRC_NONE) && src_event[c2.sync_source_select];
   assign run       = (state_reg == OCC_ST_RUN) && !done_reg;
   assign at_per    = (cnt_reg == per_act_reg);
   assign wrap      = run && tick && at_per;
   assign hit       = run && tick && (cnt_reg == duty_act_reg) &&
                      (!hi_half || cascade_lo_match_in);
   assign cascade_wrap_out  = wrap;
   assign cascade_match_out = run && tick && (cnt_reg == duty_act_reg);

   // trigger sequencing: idle, waiting for trigger, running
   always_ff @(posedge ref_clk) begin
      if (rst)
         state_reg <= OCC_ST_IDLE;
      else begin
         case (state_reg)
            OCC_ST_IDLE: if (c1.compare_mode_select != OCC_M_OFF)
                            state_reg <= trig_mode ? OCC_ST_WAIT : OCC_ST_RUN;
            OCC_ST_WAIT: if (c1.compare_mode_select == OCC_M_OFF)
                            state_reg <= OCC_ST_IDLE;
                         else if (!trig_mode)
                            state_reg <= OCC_ST_RUN;
                         else if (evt_sel)
                            state_reg <= OCC_ST_RUN;
            OCC_ST_RUN:  if (c1.compare_mode_select == OCC_M_OFF)
                            state_reg <= OCC_ST_IDLE;
                         else if (trig_mode && !flag_reg)
                            state_reg <= OCC_ST_WAIT;
            default:     state_reg <= OCC_ST_IDLE;
         endcase
      end
   end

   // trigger flag: set wins; cleared by software zero or at period end
   always_ff @(posedge ref_clk) begin
      if (rst)
         flag_reg <= 1'b0;
      else if (state_reg == OCC_ST_WAIT && trig_mode && evt_sel)
         flag_reg <= 1'b1;
      else if (wr_con2 && pstrb[0] && !pwdata[OCC_FLAG_POS])
         flag_reg <= 1'b0;
      else if (c1.trigger_clear_policy && wrap)
         flag_reg <= 1'b0;
   end

   // timer: held at zero unless running, reset by sync, restart at period
   always_ff @(posedge ref_clk) begin
      if (rst)
         cnt_reg <= '0;
      else if (!run)
         cnt_reg <= '0;
      else if (!trig_mode && evt_sel)
         cnt_reg <= '0;
      else if (tick)
         cnt_reg <= at_per ? '0 : DW'(cnt_reg + 1'b1);
   end

   // active compare values: copied from buffers outside the run state or at wrap
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         per_act_reg  <= DW'(OCC_PER_RST);
         duty_act_reg <= DW'(OCC_DUTY_RST);
      end else if (state_reg != OCC_ST_RUN || wrap) begin
         per_act_reg  <= per_buf_reg;
         duty_act_reg <= duty_buf_reg;
      end
   end

   // single pulse mode stops after its first period
   always_ff @(posedge ref_clk) begin
      if (rst)
         done_reg <= 1'b0;
      else if (state_reg != OCC_ST_RUN)
         done_reg <= 1'b0;
      else if (wrap && c1.compare_mode_select == OCC_M_PULSE1)
         done_reg <= 1'b1;
   end

   // center-aligned window around the middle of the period
   assign ctr_lo = DW'((per_act_reg - duty_act_reg) >> 1);
   assign in_win = (cnt_reg >= ctr_lo) &&
                   ({1'b0, cnt_reg} < ({1'b0, ctr_lo} + {1'b0, duty_act_reg}));

   // compare output level per mode
   always_ff @(posedge ref_clk) begin
      if (rst)
         level_reg <= 1'b0;
      else if (state_reg != OCC_ST_RUN)
         level_reg <= (c1.compare_mode_select == OCC_M_SET_LO);
      else begin
         case (c1.compare_mode_select)
            OCC_M_SET_HI: if (hit) level_reg <= 1'b1;
            OCC_M_SET_LO: if (hit) level_reg <= 1'b0;
            OCC_M_TOGGLE: if (hit) level_reg <= !level_reg;
            OCC_M_PULSE1,
            OCC_M_PULSEC: if (wrap)
                             level_reg <= 1'b0;
                          else if (hit)
                             level_reg <= 1'b1;
            OCC_M_PWM_E:  if (wrap)
                             level_reg <= (duty_buf_reg != '0);
                          else if (hit)
                             level_reg <= 1'b0;
            OCC_M_PWM_C:  level_reg <= in_win;
            default:      level_reg <= 1'b0;
         endcase
      end
   end

   // fault detection against the shared inputs
   assign fin       = {fault_input_c, fault_input_b, fault_input_a};
   assign fhit      = fin & c1.fault_enable;
   assign fault_act = (|fstat_reg) || (|fhit);

   // fault status: set wins; latched clears by software zero, else at wrap
   always_ff @(posedge ref_clk) begin
      if (rst)
         fstat_reg <= 3'b000;
      else begin
         for (int i = 0; i < 3; i++) begin
            if (fhit[i])
               fstat_reg[i] <= 1'b1;
            else if (c2.fault_latch_select) begin
               if (wr_con1 && pstrb[0] && !pwdata[OCC_FSTAT_POS + i])
                  fstat_reg[i] <= 1'b0;
            end else if (wrap || state_reg != OCC_ST_RUN)
               fstat_reg[i] <= 1'b0;
         end
      end
   end

   // pin drive: fault override, polarity and tri-state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_out_reg <= 1'b0;
         pin_oe_reg  <= 1'b0;
      end else begin
         pin_out_reg <= fault_act ? c2.fault_output_level
                                  : (level_reg ^ c2.output_invert);
         pin_oe_reg  <= !c2.output_hiz_enable &&
                        !(fault_act && c2.fault_hiz_enable);
      end
   end
   assign pin_out = pin_out_reg;
   assign pin_oe  = pin_oe_reg;

   // reload request at each period end on dma-capable channels
   always_ff @(posedge ref_clk) begin
      if (rst)
         dma_reg <= 1'b0;
      else
         dma_reg <= DMA_CAPABLE && wrap;
   end
   assign dma_req = dma_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   tb_reserved_a: assert property ((c1.timebase_select inside {3'h5, 3'h6}) && !evt_sel
                                   |=> $stable(cnt_reg) || cnt_reg == '0)
      else $error("timer moved on a reserved timebase");

   cascade_hold_a: assert property (hi_half && run && !cascade_lo_wrap_in && !evt_sel
                                    |=> $stable(cnt_reg))
      else $error("upper cascade half moved without low wrap");

   trig_hold_a: assert property (state_reg == OCC_ST_WAIT |=> cnt_reg == '0)
      else $error("timer not held while waiting for trigger");

   sync_reset_a: assert property (run && !trig_mode && evt_sel |=> cnt_reg == '0)
      else $error("sync pulse did not reset timer");

   hiz_out_a: assert property (c2.output_hiz_enable |=> !pin_oe)
      else $error("pin driven while tri-stated");

   fault_status_a: assert property (fhit[0] |=> fstat_reg[0] ##1 (fstat_reg[0] || !c2.fault_latch_select))
      else $error("fault a status not recorded");

   fault_force_a: assert property (fault_act && !c2.fault_hiz_enable && !c2.output_hiz_enable
                                   |=> pin_oe && pin_out == $past(c2.fault_output_level))
      else $error("fault level not forced");

   period_wrap_a: assert property (wrap && !evt_sel |=> cnt_reg == '0 && per_act_reg == $past(per_buf_reg)
                                   && duty_act_reg == $past(duty_buf_reg))
      else $error("period end did not restart and reload");

   trig_start_a: assert property (state_reg == OCC_ST_WAIT && trig_mode && evt_sel
                                  && c1.compare_mode_select != OCC_M_OFF
                                  |=> flag_reg && state_reg == OCC_ST_RUN)
      else $error("trigger did not start channel");

   dma_pulse_a: assert property (wrap |=> dma_req == DMA_CAPABLE ##1 (!dma_req || $past(wrap)))
      else $error("dma request not a period-end pulse");

endmodule : occ_channel

// ==== occ_load.sv ====
// Purpose: model of the circuit hanging on the compare pin
// Assumes: the pad has a weak pull-down, seen when the channel floats it
// Notes:   pad_level is what the outside world sees on the wire
`timescale 1ns/1ps
module occ_load (
   input  wire logic pin_out,   // channel pin level
   input  wire logic pin_oe,    // channel drive enable
   output logic      pad_level  // resolved wire level
);
   // a floated pin falls to the pull-down level, never the last driven value
   assign pad_level = pin_oe ? pin_out : 1'b0;
endmodule : occ_load

// ==== occ_pkg.sv ====
// Purpose: shared constants and types for the output compare channel
// Assumes: 32-bit APB data, one register per aligned word, 16-bit registers
// Notes:   fault vectors are ordered {C, B, A}, so index 0 is fault A
package occ_pkg;

   // register byte offsets
   localparam logic [11:0] OCC_CON1_OFS  = 12'h000;
   localparam logic [11:0] OCC_CON2_OFS  = 12'h004;
   localparam logic [11:0] OCC_PER_OFS   = 12'h008;
   localparam logic [11:0] OCC_DUTY_OFS  = 12'h00C;
   localparam logic [11:0] OCC_CNT_OFS   = 12'h010;

   // values after reset
   localparam logic [15:0] OCC_CON1_RST  = 16'h0000;
   localparam logic [15:0] OCC_CON2_RST  = 16'h0000;
   localparam logic [15:0] OCC_PER_RST   = 16'hFFFF;
   localparam logic [15:0] OCC_DUTY_RST  = 16'h0000;

   // software-writable bits (status and flag bits are clear-by-zero only)
   localparam logic [15:0] OCC_CON1_WMASK = 16'h1F8F;
   localparam logic [15:0] OCC_CON2_WMASK = 16'hF1BF;
   localparam logic [15:0] OCC_ALL_WMASK  = 16'hFFFF;

   // field positions used by the clear-by-zero logic
   localparam int OCC_FSTAT_POS = 4;
   localparam int OCC_FLAG_POS  = 6;

   // timebase and event source codes
   localparam logic [2:0] OCC_TB_TCY     = 3'h7;
   localparam logic [2:0] OCC_TB_TIMERS  = 3'h5;
   localparam logic [4:0] OCC_SRC_NONE   = 5'h00;

   // instruction clock divider: ref_clk cycles per instruction cycle
   localparam int         OCC_TCY_DIV  = 2;
   localparam logic [3:0] OCC_TCY_LAST = 4'(OCC_TCY_DIV - 1);

   typedef enum logic [2:0] {
      OCC_M_OFF    = 3'h0,
      OCC_M_SET_HI = 3'h1,
      OCC_M_SET_LO = 3'h2,
      OCC_M_TOGGLE = 3'h3,
      OCC_M_PULSE1 = 3'h4,
      OCC_M_PULSEC = 3'h5,
      OCC_M_PWM_E  = 3'h6,
      OCC_M_PWM_C  = 3'h7
   } occ_mode_t;

   // gray path: idle -> wait -> run
   typedef enum logic [1:0] {
      OCC_ST_IDLE = 2'b00,
      OCC_ST_WAIT = 2'b01,
      OCC_ST_RUN  = 2'b11
   } occ_state_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic [2:0] timebase_select;
      logic [2:0] fault_enable;          // {c, b, a}
      logic [2:0] fault_status;          // {c, b, a}
      logic       trigger_clear_policy;
      occ_mode_t  compare_mode_select;
   } occ_con1_t;

   typedef struct packed {
      logic       fault_latch_select;
      logic       fault_output_level;
      logic       fault_hiz_enable;
      logic       output_invert;
      logic [2:0] rsvd;
      logic       cascade_pair_enable;
      logic       trigger_not_sync_select;
      logic       trigger_armed_flag;
      logic       output_hiz_enable;
      logic [4:0] sync_source_select;
   } occ_con2_t;

endpackage : occ_pkg

// ==== test_output_compare_channel.sv ====
// Purpose: self-checking bench for the output compare channel
// Assumes: instruction clock timebase, zero-wait APB slave
// Notes:   random period and duty from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module test_output_compare_channel;
   import occ_pkg::*;
   logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        fault_input_a = 0, fault_input_b = 0, fault_input_c = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, src_event = 0, prdata, rd;
   logic [3:0]  pstrb = 0;
   logic [4:0]  timer_tick = 0;
   logic        pready, pslverr, pin_out, pin_oe, dma_req, pad_level, e;
   int          err_count = 0, checks = 0, cyc = 0, seed = 56224;
   int          hi, per, dm, d, p, lvl;
   occ_channel #(.CHAN_NUM(1), .DW(16)) dut (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_tick(timer_tick), .src_event(src_event), .fault_input_a(fault_input_a),
      .fault_input_b(fault_input_b), .fault_input_c(fault_input_c), .cascade_lo_wrap_in(1'b0),
      .cascade_lo_match_in(1'b0), .cascade_wrap_out(), .cascade_match_out(), .pin_out(pin_out),
      .pin_oe(pin_oe), .dma_req(dma_req));
   occ_load load (.pin_out(pin_out), .pin_oe(pin_oe), .pad_level(pad_level));
   // clock, random timer ticks and the hang guard
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      timer_tick <= 5'($random(seed));
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         conclude();
      end
   end
   task conclude;
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         $display("BAD %s exp %h seen %h", n, exp, seen);
         err_count = err_count + 1;
      end
   endtask : chk
   // one APB transfer: setup, then access until pready
   task apb(input logic [11:0] a, input logic w, input logic [15:0] dat);
      @(posedge ref_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, dat}; pstrb <= 4'hF;
      @(posedge ref_clk);
      penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   // one event pulse on source k
   task pulse(input int k);
      @(posedge ref_clk);
      src_event <= 32'h1 << k;
      @(posedge ref_clk);
      src_event <= 32'h0;
   endtask : pulse
   // high time, full period and dma pulses of one pwm cycle
   task meas;
      int n;
      n = 0; hi = 0; per = 0; dm = 0;
      while (pin_out !== 1'b0 && n < 300) begin @(negedge ref_clk); n++; end
      while (pin_out !== 1'b1 && n < 300) begin @(negedge ref_clk); n++; end
      while (pin_out === 1'b1 && n < 300) begin @(negedge ref_clk); n++; hi++; dm += dma_req; end
      per = hi;
      while (pin_out === 1'b0 && n < 300) begin @(negedge ref_clk); n++; per++; dm += dma_req; end
   endtask : meas
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 0;
      apb(OCC_CON1_OFS, 0, 0); chk("con1_rst", rd, 32'(OCC_CON1_RST));
      apb(OCC_PER_OFS, 0, 0); chk("per_rst", rd, 32'(OCC_PER_RST));
      apb(12'h020, 0, 0); chk("unmapped", e, 1);
      apb(OCC_CON2_OFS, 1, 16'h1000);
      repeat (3) @(negedge ref_clk); chk("inv_pin", pin_out, 1);
      apb(OCC_CON2_OFS, 1, 16'h1020);
      repeat (3) @(negedge ref_clk); chk("hiz_pad", {pin_oe, pad_level}, 0);
      apb(OCC_CON2_OFS, 1, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         p = (i == 0) ? 3 : 3 + {$random(seed)} % 8;
         d = (i == 0) ? 1 : 1 + {$random(seed)} % (p - 1);
         apb(OCC_PER_OFS, 1, 16'(p));
         apb(OCC_DUTY_OFS, 1, 16'(d));
         // enable only once a short period is buffered, or the reset period runs first
         if (i == 0) apb(OCC_CON1_OFS, 1, 16'h1C06);
         meas(); meas();
         chk("pwm_high", hi, (d + 1) * OCC_TCY_DIV);
         chk("pwm_period", per, (p + 1) * OCC_TCY_DIV);
         chk("dma_pulses", dm, 1);
      end
      // center-aligned mode keeps the period and stays high for duty ticks
      apb(OCC_CON1_OFS, 1, 16'h1C07);
      meas(); meas();
      chk("ctr_high", hi, d * OCC_TCY_DIV);
      chk("ctr_period", per, (p + 1) * OCC_TCY_DIV);
      lvl = $random(seed) & 1;
      apb(OCC_CON2_OFS, 1, 16'h8000 | 16'(lvl << 14));
      apb(OCC_CON1_OFS, 1, 16'h1CF6);
      apb(OCC_CON1_OFS, 0, 0); chk("status_wr1", rd[6:4], 0);
      apb(OCC_CON1_OFS, 1, 16'h1C86);
      @(posedge ref_clk) fault_input_a <= 1;
      repeat (3) @(negedge ref_clk); chk("flt_level", pin_out, lvl);
      apb(OCC_CON1_OFS, 0, 0); chk("flt_status", rd[6:4], 1);
      @(posedge ref_clk) fault_input_a <= 0;
      repeat (40) @(negedge ref_clk); chk("latched", pin_out, lvl);
      apb(OCC_CON1_OFS, 1, 16'h1C06);
      apb(OCC_CON1_OFS, 0, 0); chk("flt_clear", rd[6:4], 0);
      apb(OCC_CON2_OFS, 1, 16'h2000);
      @(posedge ref_clk) fault_input_b <= 1;
      repeat (3) @(negedge ref_clk); chk("b_masked", pin_oe, 1);
      apb(OCC_CON1_OFS, 1, 16'h1D06);
      repeat (3) @(negedge ref_clk); chk("flt_hiz", {pin_oe, pad_level}, 0);
      @(posedge ref_clk) fault_input_b <= 0;
      repeat (40) @(negedge ref_clk); chk("cycle_mode", pin_oe, 1);
      apb(OCC_PER_OFS, 1, 16'h0064);
      apb(OCC_CON2_OFS, 1, 16'h0083);
      repeat (10) @(negedge ref_clk);
      apb(OCC_CNT_OFS, 0, 0); chk("trig_hold", rd, 0);
      apb(OCC_CON1_OFS, 1, 16'h1D0E);
      pulse(3);
      apb(OCC_CON2_OFS, 0, 0); chk("trig_flag", rd[6], 1);
      apb(OCC_CNT_OFS, 0, 0); chk("trig_run", rd != 0, 1);
      // hardware clear at the first period end sends the channel back to waiting
      repeat (220) @(negedge ref_clk);
      apb(OCC_CON2_OFS, 0, 0); chk("trig_auto_clr", rd[6], 0);
      apb(OCC_CNT_OFS, 0, 0); chk("rearm_hold", rd, 0);
      apb(OCC_CON2_OFS, 1, 16'h0004);
      repeat (30) @(negedge ref_clk);
      pulse(4);
      apb(OCC_CNT_OFS, 0, 0); chk("sync_reset", rd < 6, 1);
      // a reserved timebase code leaves the timer frozen
      apb(OCC_CON1_OFS, 1, 16'h1406);
      apb(OCC_CNT_OFS, 0, 0);
      d = rd;
      repeat (10) @(negedge ref_clk);
      apb(OCC_CNT_OFS, 0, 0); chk("tb_reserved", rd, d);
      conclude();
   end
endmodule : test_output_compare_channel
